// ### pkg/aalo_params.svh
`ifndef AALO_PARAMS_SVH
`define AALO_PARAMS_SVH
`define AALO_RAM_DEPTH 256
`define AALO_RAM_AW 8
`define AALO_ACC_RST 8'h00
`define AALO_CY_RST 1'b0
`define AALO_DIRECT_IMM_CYCLES 2
`define AALO_BASE_CYCLES 1
`define AALO_BYTES_SHORT 2'd1
`define AALO_BYTES_MID 2'd2
`define AALO_BYTES_LONG 2'd3
`endif

// ### pkg/aalo_pkg.sv
package aalo_pkg;
  typedef enum logic [2:0] {
    AALO_OP_ADD,
    AALO_OP_ADD_WITH_CARRY,
    AALO_OP_SUBTRACT_WITH_BORROW,
    AALO_OP_LOGICAL_AND,
    AALO_OP_LOGICAL_OR
  } aalo_op_e;
  typedef enum logic [2:0] {
    AALO_SRC_REG,
    AALO_SRC_DIRECT,
    AALO_SRC_INDIRECT,
    AALO_SRC_IMM,
    AALO_SRC_DIR_ACC,
    AALO_SRC_DIR_IMM
  } aalo_src_e;
  typedef enum logic {
    AALO_ST_IDLE,
    AALO_ST_SECOND
  } aalo_state_e;
endpackage : aalo_pkg

// ### rtl/aalo_alu.sv
`timescale 1ns/100ps
module aalo_alu
  import aalo_pkg::*;
(
  input wire aalo_op_e op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic cy_in,
  output logic [7:0] res_out,
  output logic cy_out
);
  logic [8:0] sum;
  always_comb begin
    sum = 9'h000;
    res_out = 8'h00;
    cy_out = cy_in;
    case (op_in)
      AALO_OP_ADD: begin
        sum = {1'b0, a_in} + {1'b0, b_in};
        res_out = sum[7:0];
        cy_out = sum[8];
      end
      AALO_OP_ADD_WITH_CARRY: begin
        sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cy_in};
        res_out = sum[7:0];
        cy_out = sum[8];
      end
      AALO_OP_SUBTRACT_WITH_BORROW: begin
        sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cy_in};
        res_out = sum[7:0];
        cy_out = sum[8];
      end
      AALO_OP_LOGICAL_AND: begin
        res_out = a_in & b_in;
      end
      default: begin
        res_out = a_in | b_in;
      end
    endcase
  end
endmodule : aalo_alu

// ### rtl/aalo_core.sv
`timescale 1ns/100ps
`include "aalo_params.svh"
module aalo_core
  import aalo_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire aalo_op_e op_in,
  input wire aalo_src_e src_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [7:0] direct_addr_in,
  input wire logic [7:0] imm_in,
  input wire logic ptr_sel_in,
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic busy_out,
  output logic done_out,
  output logic [1:0] bytes_out,
  output logic [7:0] ram_wr_addr_out,
  output logic [7:0] ram_wr_data_out,
  output logic ram_wr_out
);
  logic [7:0] ram_q [0:`AALO_RAM_DEPTH-1];
  // sequencer
  aalo_state_e st_q, st_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic [1:0] bytes_q, bytes_d;
  logic [7:0] hold_addr_q, hold_addr_d;
  logic [7:0] hold_imm_q, hold_imm_d;
  aalo_op_e hold_op_q, hold_op_d;
  // accumulator and carry
  logic [7:0] acc_q, acc_d;
  logic cy_q, cy_d;
  // direct byte write port
  logic wr_q, wr_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  // datapath
  logic [7:0] operand, alu_a, alu_res;
  logic alu_cy;
  aalo_op_e alu_op;
  logic take, second;

  // bytes 0..7 of ram serve as the register bank; pointer registers are 0 and 1
  function automatic logic [7:0] fetch_operand(input aalo_src_e src, input logic [2:0] rs,
      input logic [7:0] da, input logic [7:0] im, input logic ps, input logic [7:0] acc);
    case (src)
      AALO_SRC_REG: fetch_operand = ram_q[{5'h00, rs}];
      AALO_SRC_DIRECT: fetch_operand = ram_q[da];
      AALO_SRC_INDIRECT: fetch_operand = ram_q[ram_q[{7'h00, ps}]];
      AALO_SRC_DIR_ACC: fetch_operand = acc;
      default: fetch_operand = im;
    endcase
  endfunction : fetch_operand

  function automatic logic [1:0] encoded_bytes(input aalo_src_e src);
    case (src)
      AALO_SRC_REG, AALO_SRC_INDIRECT: encoded_bytes = `AALO_BYTES_SHORT;
      AALO_SRC_DIR_IMM: encoded_bytes = `AALO_BYTES_LONG;
      default: encoded_bytes = `AALO_BYTES_MID;
    endcase
  endfunction : encoded_bytes

  function automatic logic is_arith(input aalo_op_e op);
    is_arith = (op != AALO_OP_LOGICAL_AND) && (op != AALO_OP_LOGICAL_OR);
  endfunction : is_arith

  function automatic logic to_direct(input aalo_src_e src);
    to_direct = (src == AALO_SRC_DIR_ACC) || (src == AALO_SRC_DIR_IMM);
  endfunction : to_direct

  always_comb begin
    operand = fetch_operand(src_in, reg_sel_in, direct_addr_in, imm_in, ptr_sel_in, acc_q);
    alu_a = acc_q;
    alu_op = op_in;
    if (st_q == AALO_ST_SECOND) begin
      alu_a = ram_q[hold_addr_q];
      alu_op = hold_op_q;
      operand = hold_imm_q;
    end else if (to_direct(src_in)) begin
      alu_a = ram_q[direct_addr_in];
    end
  end

  aalo_alu u_alu (
    .op_in(alu_op),
    .a_in(alu_a),
    .b_in(operand),
    .cy_in(cy_q),
    .res_out(alu_res),
    .cy_out(alu_cy)
  );

  assign second = (st_q == AALO_ST_SECOND);
  // a start seen while the second cycle runs is dropped, not queued
  assign take = start_in && !second;

  // sequencer: instruction length, busy and done
  always_comb begin
    st_d = st_q;
    busy_d = 1'b0;
    done_d = 1'b0;
    bytes_d = bytes_q;
    hold_addr_d = hold_addr_q;
    hold_imm_d = hold_imm_q;
    hold_op_d = hold_op_q;
    case (st_q)
      AALO_ST_IDLE: begin
        if (take) begin
          bytes_d = encoded_bytes(src_in);
          if (src_in == AALO_SRC_DIR_IMM) begin
            // second machine cycle does the read-modify-write of the direct byte
            st_d = AALO_ST_SECOND;
            busy_d = 1'b1;
            hold_addr_d = direct_addr_in;
            hold_imm_d = imm_in;
            hold_op_d = op_in;
          end else begin
            done_d = 1'b1;
          end
        end
      end
      default: begin
        done_d = 1'b1;
        st_d = AALO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= AALO_ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      bytes_q <= 2'h0;
      hold_addr_q <= 8'h00;
      hold_imm_q <= 8'h00;
      hold_op_q <= AALO_OP_ADD;
    end else begin
      st_q <= st_d;
      busy_q <= busy_d;
      done_q <= done_d;
      bytes_q <= bytes_d;
      hold_addr_q <= hold_addr_d;
      hold_imm_q <= hold_imm_d;
      hold_op_q <= hold_op_d;
    end
  end

  // accumulator and carry change only for a start whose destination is the accumulator
  always_comb begin
    acc_d = acc_q;
    cy_d = cy_q;
    if (take && !to_direct(src_in)) begin
      acc_d = alu_res;
      if (is_arith(op_in)) begin
        cy_d = alu_cy;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      acc_q <= `AALO_ACC_RST;
      cy_q <= `AALO_CY_RST;
    end else begin
      acc_q <= acc_d;
      cy_q <= cy_d;
    end
  end

  // direct byte write port; its pulse stands in the same cycle as done
  always_comb begin
    wr_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    if (second) begin
      wr_d = 1'b1;
      waddr_d = hold_addr_q;
      wdata_d = alu_res;
    end else if (take && src_in == AALO_SRC_DIR_ACC) begin
      wr_d = 1'b1;
      waddr_d = direct_addr_in;
      wdata_d = alu_res;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      wr_q <= wr_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  // data memory has no reset; it starts unknown until written
  // written from the next-state values so an op taken at the following edge
  // already reads the new byte; no write lands while reset is held
  always_ff @(posedge sys_clk_in) begin
    if (wr_d && !rst_in) begin
      ram_q[waddr_d] <= wdata_d;
    end
  end

  assign acc_out = acc_q;
  assign carry_out = cy_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign bytes_out = bytes_q;
  assign ram_wr_addr_out = waddr_q;
  assign ram_wr_data_out = wdata_q;
  assign ram_wr_out = wr_q;
endmodule : aalo_core

// ### test/aalo_core_monitor.sv
`timescale 1ns/100ps
module aalo_core_monitor
  import aalo_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire aalo_op_e op_in,
  input wire aalo_src_e src_in,
  input wire logic [7:0] direct_addr_in,
  input wire logic [7:0] imm_in,
  input wire logic [7:0] acc_out,
  input wire logic carry_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [1:0] bytes_out,
  input wire logic [7:0] ram_wr_addr_out,
  input wire logic ram_wr_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire go = start_in && !busy_out;
  sequence s_dimm; go && src_in == AALO_SRC_DIR_IMM; endsequence
  sequence s_fin; done_out && ram_wr_out && !busy_out; endsequence
  property p_dimm; s_dimm |=> busy_out && bytes_out == 2'd3 ##1 s_fin; endproperty
  a_dimm: assert property (p_dimm) else $error("dimm");
  property p_one; go && src_in != AALO_SRC_DIR_IMM |=> done_out && !busy_out; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_short;
    go && src_in inside {AALO_SRC_REG, AALO_SRC_INDIRECT} |=> bytes_out == 2'd1;
  endproperty
  a_short: assert property (p_short) else $error("short");
  property p_mid;
    go && src_in inside {AALO_SRC_DIRECT, AALO_SRC_IMM, AALO_SRC_DIR_ACC} |=> bytes_out == 2'd2;
  endproperty
  a_mid: assert property (p_mid) else $error("mid");
  property p_keep;
    go && op_in inside {AALO_OP_LOGICAL_AND, AALO_OP_LOGICAL_OR} |=> $stable(carry_out);
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_add; go && op_in == AALO_OP_ADD && src_in == AALO_SRC_IMM
    |=> {carry_out, acc_out} == {1'b0, $past(acc_out)} + $past(imm_in); endproperty
  a_add: assert property (p_add) else $error("add");
  property p_wr; go && src_in == AALO_SRC_DIR_ACC
    |=> ram_wr_out && ram_wr_addr_out == $past(direct_addr_in); endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_pulse; ram_wr_out |-> done_out; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
endmodule : aalo_core_monitor
bind aalo_core aalo_core_monitor u_mon (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .start_in(start_in),
  .op_in(op_in),
  .src_in(src_in),
  .direct_addr_in(direct_addr_in),
  .imm_in(imm_in),
  .acc_out(acc_out),
  .carry_out(carry_out),
  .busy_out(busy_out),
  .done_out(done_out),
  .bytes_out(bytes_out),
  .ram_wr_addr_out(ram_wr_addr_out),
  .ram_wr_out(ram_wr_out)
);

// ### test/test_accumulator_arith_logic_ops.sv
`timescale 1ns/100ps
module test_accumulator_arith_logic_ops
  import aalo_pkg::*;
;
  logic sys_clk_in = 0, rst_in = 1, start_in = 0, ptr_sel_in = 0;
  logic carry_out, busy_out, done_out, ram_wr_out;
  aalo_op_e op_in = AALO_OP_ADD;
  aalo_src_e src_in = AALO_SRC_REG;
  logic [2:0] reg_sel_in = 0;
  logic [7:0] direct_addr_in = 0, imm_in = 0, acc_out, ram_wr_addr_out, ram_wr_data_out;
  logic [1:0] bytes_out;
  logic [31:0] seed = 94;
  int num_errors = 0, cmp_count = 0, cyc = 0, acc = 0, cy = 0, ram [256];
  aalo_core u_dut (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .start_in(start_in),
    .op_in(op_in),
    .src_in(src_in),
    .reg_sel_in(reg_sel_in),
    .direct_addr_in(direct_addr_in),
    .imm_in(imm_in),
    .ptr_sel_in(ptr_sel_in),
    .acc_out(acc_out),
    .carry_out(carry_out),
    .busy_out(busy_out),
    .done_out(done_out),
    .bytes_out(bytes_out),
    .ram_wr_addr_out(ram_wr_addr_out),
    .ram_wr_data_out(ram_wr_data_out),
    .ram_wr_out(ram_wr_out)
  );
  always #20 sys_clk_in = ~sys_clk_in;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(string n, int e, logic [8:0] g);
    cmp_count++;
    if (g !== e[8:0]) begin
      num_errors++;
      $display("MISMATCH %s exp %0d got %0d", n, e, g);
    end
  endtask : chk
  task complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic run(aalo_op_e o, aalo_src_e s, int d, int im);
    logic [31:0] r;
    int a, b, x;
    r = xs();
    d &= 255;
    im &= 255;
    @(negedge sys_clk_in);
    // the previous done and write pulses stand one cycle only; a refused start adds none
    chk("done_low", 0, done_out);
    chk("wr_low", 0, ram_wr_out);
    op_in = o;
    src_in = s;
    reg_sel_in = r[2:0];
    ptr_sel_in = r[3];
    direct_addr_in = d[7:0];
    imm_in = im[7:0];
    start_in = 1;
    a = (s >= AALO_SRC_DIR_ACC) ? ram[d] : acc;
    b = (s == AALO_SRC_REG) ? ram[r[2:0]] : (s == AALO_SRC_DIRECT) ? ram[d] :
        (s == AALO_SRC_INDIRECT) ? ram[ram[r[3]]] : (s == AALO_SRC_DIR_ACC) ? acc : im;
    case (o)
      AALO_OP_ADD: x = a + b;
      AALO_OP_ADD_WITH_CARRY: x = a + b + cy;
      AALO_OP_SUBTRACT_WITH_BORROW: x = a - b - cy;
      AALO_OP_LOGICAL_AND: x = a & b;
      default: x = a | b;
    endcase
    @(negedge sys_clk_in);
    // start stays high through the busy cycle and must be ignored
    if (s == AALO_SRC_DIR_IMM) begin
      chk("busy", 1, busy_out);
      @(negedge sys_clk_in);
    end
    start_in = 0;
    chk("busy_end", 0, busy_out);
    if (s < AALO_SRC_DIR_ACC) begin
      acc = x & 255;
      if (o < AALO_OP_LOGICAL_AND) cy = (x >> 8) & 1;
      chk("wr", 0, ram_wr_out);
    end else begin
      ram[d] = x & 255;
      chk("wr", 1, ram_wr_out);
      chk("waddr", d, ram_wr_addr_out);
      chk("wdata", ram[d], ram_wr_data_out);
    end
    chk("done", 1, done_out);
    chk("acc", acc, acc_out);
    chk("carry", cy, carry_out);
    chk("len", s inside {AALO_SRC_REG, AALO_SRC_INDIRECT} ? 1 :
        (s == AALO_SRC_DIR_IMM) ? 3 : 2, bytes_out);
  endtask : run
  initial begin
    repeat (4) @(negedge sys_clk_in);
    rst_in = 0;
    for (int i = 0; i < 256; i++) begin
      run(AALO_OP_LOGICAL_AND, AALO_SRC_DIR_IMM, i, 0);
      run(AALO_OP_LOGICAL_OR, AALO_SRC_DIR_IMM, i, xs());
    end
    repeat (500) run(aalo_op_e'(xs() % 5), aalo_src_e'(xs() % 6), xs(), xs());
    complete_run();
  end
endmodule : test_accumulator_arith_logic_ops
